// File: common/usrx_pkg.sv
// Purpose: Shared constants, types and state layout for the receiver.
// Assumes: APB slave with 32-bit data; one register per aligned word.
// Notes:   Printed offsets are register indices; byte address = 4 * index.

package usrx_pkg;

    // ========================================================
    // Register indices
    localparam int         IDX_W     = 8;
    localparam logic [7:0] IDX_FLAG  = 8'h0C;
    localparam logic [7:0] IDX_RECEIVE_STATUS_CONTROL = 8'h18;
    localparam logic [7:0] IDX_RCBUF = 8'h1A;
    localparam logic [7:0] IDX_PIE   = 8'h8C;
    localparam logic [7:0] IDX_TRANSMIT_STATUS_CONTROL = 8'h98;
    localparam logic [7:0] IDX_BAUD  = 8'h99;

    // ========================================================
    // Field positions
    localparam int B_RECEIVE_DONE_FLAG = 5;
    localparam int B_RECEIVE_IRQ_ENABLE = 5;
    localparam int B_SERIAL_PORT_ENABLE = 7;
    localparam int B_RX9  = 6;
    localparam int B_SINGLE_WORD_RECEIVE_ENABLE = 5;
    localparam int B_CONTINUOUS_RECEIVE_ENABLE = 4;
    localparam int B_OVERRUN_ERROR_BIT = 1;
    localparam int B_NINTH_RECEIVED_BIT = 0;
    localparam int B_CLOCK_SOURCE_MASTER_SELECT = 7;
    localparam int B_SYNC = 4;
    localparam int B_SHIFT_REGISTER_EMPTY = 1;

    // ========================================================
    // Reset values and write masks
    localparam logic [7:0] RST_RECEIVE_STATUS_CONTROL   = 8'h00;
    localparam logic [7:0] RST_TRANSMIT_STATUS_CONTROL   = 8'h02;
    localparam logic [7:0] RST_BAUD    = 8'h00;
    localparam logic [7:0] RST_PIE     = 8'h00;
    localparam logic [7:0] RECEIVE_STATUS_CONTROL_WMASK = 8'hF0;
    localparam logic [7:0] TRANSMIT_STATUS_CONTROL_WMASK = 8'hF5;

    // ========================================================
    // Word sizes and buffer depth
    localparam logic [3:0] NBITS_8    = 4'h8;
    localparam logic [3:0] NBITS_9    = 4'h9;
    localparam logic [1:0] FIFO_DEPTH = 2'h2;

    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_SHIFT = 2'b01,
        ST_LOAD  = 2'b11
    } usrx_state_e;

    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
    } usrx_apb_req_s;

    typedef struct packed {
        logic [31:0] prdata;
        logic        pready;
        logic        pslverr;
    } usrx_apb_rsp_s;

    typedef struct packed {
        usrx_state_e     st;
        logic [7:0]      div_cnt;
        logic            sck;
        logic            oe;
        logic [3:0]      bit_cnt;
        logic [8:0]      shreg;
        logic [1:0][8:0] fifo;
        logic [1:0]      cnt;
        logic            rd_ptr;
        logic            overrun_error_bit;
        logic [7:0]      receive_status_control_w;
        logic [7:0]      transmit_status_control_w;
        logic [7:0]      baud;
        logic [7:0]      pie;
        usrx_apb_rsp_s   rsp;
        logic            irq;
        logic            ds1;
        logic            ds2;
    } usrx_state_s;

endpackage

// File: hdl/usrx_sync_rx.sv
// Purpose: Synchronous master serial receiver with two-entry buffer.
// Assumes: pclk 100 MHz; data pin is asynchronous to pclk.
// Notes:   Serial clock idles low; bits are taken as it falls.
//
// Overview of operation
// - Reception starts only when single-word or continuous enable is set.
// - Each data bit is sampled at the falling serial clock edge.
// - Single-word enable alone receives one word, then clears itself.
// - Continuous enable keeps receiving words until software clears it.
// - With both enables set, continuous behaviour wins.
// - Completed word moves from shift register to buffer if room.
// - Receive flag is set once a word sits in the buffer.
// - Interrupt output follows flag only while receive interrupt enabled.
// - Flag is read-only; it clears when buffer is read empty.
// - Buffer holds two words while a third is shifting.
// - Full buffer at last bit of third word: overrun set, word dropped.
// - While overrun is set, no word enters the buffer.
// - Ninth bit is queued alongside each data byte.
// - Reading buffer exposes next entry's ninth bit; read status first.
// - Nine-bit select chooses nine-bit words, else eight-bit words.
//
// The APB register port is this design's own decision.

`timescale 1ns/1ps

module usrx_sync_rx
    import usrx_pkg::*;
(
    // Clock, reset, enable
    input  wire logic          pclk,
    input  wire logic          presetn,
    input  wire logic          ce,
    // APB slave
    input  wire usrx_apb_req_s apb_req,
    output usrx_apb_rsp_s      apb_rsp,
    // Serial clock pin
    output logic               sck_out,
    output logic               sck_oe,
    // Serial data pin
    input  wire logic          sdata_in,
    output logic               sdata_out,
    output logic               sdata_oe,
    // Receive interrupt
    output logic               rx_irq
);

    usrx_state_s r_reg;
    usrx_state_s r_next;

    // ========================================================
    // Helpers
    function automatic logic [31:0] zx8(input logic [7:0] v);
        return {24'h000000, v};
    endfunction

    function automatic logic idx_hit(input logic [7:0] idx);
        return (apb_req.paddr[11:10] == 2'b00)
            && (apb_req.paddr[1:0] == 2'b00)
            && (apb_req.paddr[9:2] == idx);
    endfunction

    // ========================================================
    // Decoded controls
    logic       port_on;
    logic       single_word_receive_enable;
    logic       continuous_receive_enable;
    logic       rx_run;
    logic [3:0] nbits;
    logic [8:0] head;
    logic       setup;
    logic       access;
    logic       mapped;
    logic       next_ninth;

    always_comb begin
        port_on = r_reg.receive_status_control_w[B_SERIAL_PORT_ENABLE] && r_reg.transmit_status_control_w[B_SYNC]
               && r_reg.transmit_status_control_w[B_CLOCK_SOURCE_MASTER_SELECT];
        single_word_receive_enable    = r_reg.receive_status_control_w[B_SINGLE_WORD_RECEIVE_ENABLE];
        continuous_receive_enable    = r_reg.receive_status_control_w[B_CONTINUOUS_RECEIVE_ENABLE];
        rx_run  = port_on && (single_word_receive_enable || continuous_receive_enable);
        nbits   = r_reg.receive_status_control_w[B_RX9] ? NBITS_9 : NBITS_8;
        head    = r_reg.fifo[r_reg.rd_ptr];
        setup   = apb_req.psel && !apb_req.penable;
        access  = apb_req.psel && apb_req.penable && r_reg.rsp.pready;
        mapped  = idx_hit(IDX_FLAG) || idx_hit(IDX_RECEIVE_STATUS_CONTROL)
               || idx_hit(IDX_RCBUF) || idx_hit(IDX_PIE)
               || idx_hit(IDX_TRANSMIT_STATUS_CONTROL) || idx_hit(IDX_BAUD);
        next_ninth = r_reg.fifo[!r_reg.rd_ptr][8];
    end

    // ========================================================
    // Next-state logic
    logic       pop;
    logic       push;
    logic       word_done;
    logic [7:0] wbyte;
    logic [7:0] receive_status_control_rd;

    always_comb begin
        r_next    = r_reg;
        pop       = 1'b0;
        push      = 1'b0;
        word_done = 1'b0;
        wbyte     = apb_req.pwdata[7:0];
        receive_status_control_rd  = r_reg.receive_status_control_w;
        receive_status_control_rd[B_OVERRUN_ERROR_BIT] = r_reg.overrun_error_bit;
        receive_status_control_rd[B_NINTH_RECEIVED_BIT] = head[8];

        // Data pin synchroniser; pin is never driven
        r_next.ds1 = sdata_in;
        r_next.ds2 = r_reg.ds1;

        // ---- Bus: answer registered one cycle after setup
        r_next.rsp.pready  = 1'b0;
        r_next.rsp.pslverr = 1'b0;
        if (setup) begin
            r_next.rsp.pready  = 1'b1;
            r_next.rsp.pslverr = !mapped;
            r_next.rsp.prdata  = 32'h00000000;
            if (!apb_req.pwrite) begin
                if (idx_hit(IDX_FLAG)) begin
                    r_next.rsp.prdata[B_RECEIVE_DONE_FLAG] = (r_reg.cnt != 2'h0);
                end
                if (idx_hit(IDX_RECEIVE_STATUS_CONTROL)) begin
                    r_next.rsp.prdata = zx8(receive_status_control_rd);
                end
                if (idx_hit(IDX_RCBUF)) begin
                    r_next.rsp.prdata = zx8(head[7:0]);
                end
                if (idx_hit(IDX_PIE)) begin
                    r_next.rsp.prdata = zx8(r_reg.pie);
                end
                if (idx_hit(IDX_TRANSMIT_STATUS_CONTROL)) begin
                    r_next.rsp.prdata = zx8(r_reg.transmit_status_control_w
                                            | (8'h01 << B_SHIFT_REGISTER_EMPTY));
                end
                if (idx_hit(IDX_BAUD)) begin
                    r_next.rsp.prdata = zx8(r_reg.baud);
                end
            end
        end

        if (access && !r_reg.rsp.pslverr) begin
            if (apb_req.pwrite) begin
                if (idx_hit(IDX_RECEIVE_STATUS_CONTROL)) begin
                    r_next.receive_status_control_w = wbyte & RECEIVE_STATUS_CONTROL_WMASK;
                end
                if (idx_hit(IDX_PIE)) begin
                    r_next.pie = wbyte;
                end
                if (idx_hit(IDX_TRANSMIT_STATUS_CONTROL)) begin
                    r_next.transmit_status_control_w = wbyte & TRANSMIT_STATUS_CONTROL_WMASK;
                end
                if (idx_hit(IDX_BAUD)) begin
                    r_next.baud = wbyte;
                end
            end else if (idx_hit(IDX_RCBUF) && r_reg.cnt != 2'h0) begin
                pop = 1'b1;
            end
        end

        // Overrun only clears with continuous enable low
        if (!r_next.receive_status_control_w[B_CONTINUOUS_RECEIVE_ENABLE]) begin
            r_next.overrun_error_bit = 1'b0;
        end

        // ---- Serial engine
        case (r_reg.st)
            ST_IDLE: begin
                r_next.sck     = 1'b0;
                r_next.div_cnt = 8'h00;
                r_next.bit_cnt = 4'h0;
                if (rx_run) begin
                    r_next.st = ST_SHIFT;
                end
            end
            ST_SHIFT: begin
                if (!rx_run) begin
                    // Enable dropped mid-word: abandon partial word
                    r_next.st  = ST_IDLE;
                    r_next.sck = 1'b0;
                end else if (r_reg.div_cnt == r_reg.baud) begin
                    r_next.div_cnt = 8'h00;
                    r_next.sck     = !r_reg.sck;
                    if (r_reg.sck) begin
                        // Falling edge: take one bit, LSB first
                        r_next.shreg   = {r_reg.ds2, r_reg.shreg[8:1]};
                        r_next.bit_cnt = r_reg.bit_cnt + 4'h1;
                        if (r_reg.bit_cnt + 4'h1 == nbits) begin
                            r_next.st = ST_LOAD;
                        end
                    end
                end else begin
                    r_next.div_cnt = r_reg.div_cnt + 8'h01;
                end
            end
            ST_LOAD: begin
                word_done      = 1'b1;
                r_next.bit_cnt = 4'h0;
                r_next.div_cnt = 8'h00;
                if (continuous_receive_enable && port_on) begin
                    r_next.st = ST_SHIFT;
                end else begin
                    r_next.st = ST_IDLE;
                    if (!continuous_receive_enable) begin
                        r_next.receive_status_control_w[B_SINGLE_WORD_RECEIVE_ENABLE] = 1'b0;
                    end
                end
            end
            default: begin
                r_next.st  = ST_IDLE;
                r_next.sck = 1'b0;
            end
        endcase

        // ---- Buffer: completed word enters unless blocked
        if (word_done) begin
            if (r_reg.overrun_error_bit) begin
                push = 1'b0;
            end else if (r_reg.cnt == FIFO_DEPTH && !pop) begin
                r_next.overrun_error_bit = 1'b1;
            end else begin
                push = 1'b1;
            end
        end

        if (push) begin
            // 8-bit words align to low byte; ninth bit rides along
            if (nbits == NBITS_9) begin
                r_next.fifo[r_reg.rd_ptr ^ (r_reg.cnt != 2'h0)
                            ^ pop] = r_next.shreg;
            end else begin
                r_next.fifo[r_reg.rd_ptr ^ (r_reg.cnt != 2'h0)
                            ^ pop] = {1'b0, r_next.shreg[8:1]};
            end
        end
        if (pop) begin
            r_next.rd_ptr = !r_reg.rd_ptr;
        end
        case ({push, pop})
            2'b10:   r_next.cnt = r_reg.cnt + 2'h1;
            2'b01:   r_next.cnt = r_reg.cnt - 2'h1;
            default: r_next.cnt = r_reg.cnt;
        endcase

        // Pin drive registered so the pad enable never glitches
        r_next.oe = r_next.receive_status_control_w[B_SERIAL_PORT_ENABLE] && r_next.transmit_status_control_w[B_SYNC]
                 && r_next.transmit_status_control_w[B_CLOCK_SOURCE_MASTER_SELECT];

        // Flag derived from fill level, so a push beats a pop
        r_next.irq = (r_next.cnt != 2'h0) && r_next.pie[B_RECEIVE_IRQ_ENABLE];
    end

    // ========================================================
    // State register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            r_reg         <= '0;
            r_reg.st      <= ST_IDLE;
            r_reg.receive_status_control_w <= RST_RECEIVE_STATUS_CONTROL;
            r_reg.transmit_status_control_w <= RST_TRANSMIT_STATUS_CONTROL & TRANSMIT_STATUS_CONTROL_WMASK;
            r_reg.baud    <= RST_BAUD;
            r_reg.pie     <= RST_PIE;
        end else if (ce) begin
            r_reg <= r_next;
        end
    end

    // ========================================================
    // Outputs
    always_comb begin
        apb_rsp   = r_reg.rsp;
        sck_out   = r_reg.sck;
        sck_oe    = r_reg.oe;
        sdata_out = 1'b0;
        sdata_oe  = 1'b0;
        rx_irq    = r_reg.irq;
    end

    // ========================================================
    // Assertions
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_fall;
        ce && r_reg.st == ST_SHIFT && r_reg.sck && !r_next.sck && rx_run;
    endsequence

    sequence s_word_in;
        ce && word_done && push;
    endsequence

    a_idle_no_clock: assert property (
        !rx_run && r_reg.st != ST_LOAD |=> !r_reg.sck)
        else $error("serial clock toggles while receive disabled");

    a_idle_waits: assert property (
        ce && r_reg.st == ST_IDLE && !rx_run |=> r_reg.st == ST_IDLE)
        else $error("engine left idle without an enable");

    a_sample_on_fall: assert property (
        s_fall |=> r_reg.shreg[8] == $past(r_reg.ds2))
        else $error("bit not taken at falling clock");

    a_single_stops: assert property (
        ce && r_reg.st == ST_LOAD && !continuous_receive_enable |=> !single_word_receive_enable
        && r_reg.st == ST_IDLE)
        else $error("single-word mode did not stop");

    a_cont_keeps: assert property (
        ce && r_reg.st == ST_LOAD && continuous_receive_enable && port_on
        |=> r_reg.st == ST_SHIFT)
        else $error("continuous mode did not resume");

    a_push_count: assert property (
        (s_word_in and !pop) |=> r_reg.cnt == $past(r_reg.cnt) + 2'h1)
        else $error("word not moved into buffer");

    a_flag_set: assert property (
        s_word_in |=> r_reg.cnt != 2'h0)
        else $error("flag not set after word entered buffer");

    a_flag_irq: assert property (
        ce |=> rx_irq == ((r_reg.cnt != 2'h0)
                          && r_reg.pie[B_RECEIVE_IRQ_ENABLE]))
        else $error("interrupt disagrees with flag and enable");

    a_irq_masked: assert property (
        ce && !r_next.pie[B_RECEIVE_IRQ_ENABLE] |=> !rx_irq)
        else $error("interrupt raised while masked");

    // A word may land right after the read, so check one cycle only
    a_flag_clears: assert property (
        ce && pop && r_reg.cnt == 2'h1 && !push
        |=> r_reg.cnt == 2'h0 && !rx_irq)
        else $error("flag stayed after buffer emptied");

    a_pop_count: assert property (
        ce && pop && !push |=> r_reg.cnt == $past(r_reg.cnt) - 2'h1)
        else $error("buffer read did not free an entry");

    a_depth_two: assert property (
        r_reg.cnt <= FIFO_DEPTH)
        else $error("buffer above two entries");

    a_overrun_set: assert property (
        ce && word_done && !r_reg.overrun_error_bit && r_reg.cnt == FIFO_DEPTH
        && !pop |=> r_reg.overrun_error_bit && r_reg.cnt == FIFO_DEPTH)
        else $error("overrun not flagged or word kept");

    a_overrun_blocks: assert property (
        r_reg.overrun_error_bit |-> !push)
        else $error("transfer while overrun set");

    // A word ending in the same cycle sets overrun; set wins
    a_overrun_clear: assert property (
        ce && !r_next.receive_status_control_w[B_CONTINUOUS_RECEIVE_ENABLE] && r_reg.st != ST_LOAD
        |=> !r_reg.overrun_error_bit)
        else $error("overrun survived continuous enable clear");

    a_ninth_status: assert property (
        ce && pop && r_reg.cnt == 2'h2
        |=> receive_status_control_rd[B_NINTH_RECEIVED_BIT] == $past(next_ninth))
        else $error("ninth bit not from next entry");

    a_half_period: assert property (
        ce && r_reg.st == ST_SHIFT && rx_run && r_next.sck != r_reg.sck
        |-> r_reg.div_cnt == r_reg.baud)
        else $error("serial clock edge off divisor count");

    a_oe_follows: assert property (
        ce |=> sck_oe == port_on)
        else $error("clock pin drive disagrees with mode");

    a_bad_addr: assert property (
        ce && setup && !mapped |=> apb_rsp.pslverr)
        else $error("unmapped access not refused");

endmodule

// File: tb/usrx_slave_model.sv
// Purpose: Serial slave that shifts words out on the master's clock.
// Assumes: Data changes on the rising serial clock edge, LSB first.
// Notes:   Once its four words are spent the line toggles every clock.

`timescale 1ns/1ps

module usrx_slave_model (
    // Link
    input  wire logic            sck,
    output logic                 sdata,
    // Control from the bench
    input  wire logic            restart,
    input  wire logic [3:0]      nbits,
    input  wire logic [3:0][8:0] words,
    output int                   rises
);
    // ========================================================
    // Shifter
    always @(posedge sck or posedge restart) begin
        if (restart) begin
            rises <= 0;
            sdata <= 1'b1;
        end else begin
            // Past the last word: no stale bit may pass for data
            if (rises / nbits < 4)
                sdata <= words[rises / nbits][rises % nbits];
            else
                sdata <= ~sdata;
            rises <= rises + 1;
        end
    end
endmodule

// File: tb/tb_top.sv
// Purpose: Self-checking bench for the synchronous master receiver.
// Assumes: Divisor 7 gives a 160 ns serial clock at 100 MHz.
// Notes:   Registers reached at byte address 4 * index.

`timescale 1ns/1ps

module tb_top
    import usrx_pkg::*;
;
    logic            pclk;
    logic            presetn;
    logic            restart;
    usrx_apb_req_s   req;
    usrx_apb_rsp_s   rsp;
    logic            sck_out;
    logic            sck_oe;
    logic            sdata;
    logic            d_out;
    logic            d_oe;
    logic            dline;
    logic            rx_irq;
    logic [3:0]      nbits;
    logic [3:0][8:0] words;
    logic [31:0]     rd;
    logic            err;
    int              rises;
    int              s;
    int              sck_cnt = 0;
    int              error_cnt = 0;
    int              checked = 0;
    logic [7:0]      ridx [6] = '{IDX_FLAG, IDX_RECEIVE_STATUS_CONTROL, IDX_RCBUF,
                                  IDX_PIE, IDX_TRANSMIT_STATUS_CONTROL, IDX_BAUD};
    logic [7:0]      rrst [6] = '{8'h00, RST_RECEIVE_STATUS_CONTROL, 8'h00,
                                  RST_PIE, RST_TRANSMIT_STATUS_CONTROL, RST_BAUD};

    assign dline = d_oe ? d_out : sdata;

    usrx_sync_rx dut (
        .pclk      (pclk),
        .presetn   (presetn),
        .ce        (1'b1),
        .apb_req   (req),
        .apb_rsp   (rsp),
        .sck_out   (sck_out),
        .sck_oe    (sck_oe),
        .sdata_in  (dline),
        .sdata_out (d_out),
        .sdata_oe  (d_oe),
        .rx_irq    (rx_irq)
    );

    usrx_slave_model slave (
        .sck     (sck_out),
        .sdata   (sdata),
        .restart (restart),
        .nbits   (nbits),
        .words   (words),
        .rises   (rises)
    );

    always @(posedge sck_out) sck_cnt++;

    // ========================================================
    // Tasks
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic apb(input logic wr, input logic [7:0] idx,
                       input logic [7:0] wd);
        int n;
        @(posedge pclk);
        req <= '{1'b1, 1'b0, wr, {2'b00, idx, 2'b00}, {24'h0, wd}};
        @(posedge pclk);
        req.penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (rsp.pready !== 1'b1 && n < 20);
        if (n >= 20) error_cnt++;
        rd = rsp.prdata;
        err = rsp.pslverr;
        req.psel <= 1'b0;
        req.penable <= 1'b0;
    endtask

    // Polls a register bit; bounded so a dead receiver cannot hang us
    task automatic wait_bit(input logic [7:0] idx, input int b);
        int n;
        n = 0;
        do begin
            apb(1'b0, idx, 8'h00);
            n++;
        end while (rd[b] !== 1'b1 && n < 600);
    endtask

    task automatic pulse_restart;
        @(posedge pclk);
        restart <= 1'b1;
        @(posedge pclk);
        restart <= 1'b0;
    endtask

    task automatic report_and_stop;
        if (error_cnt == 0 && checked > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    // ========================================================
    // Clock and watchdog
    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end

    initial begin
        repeat (30000) @(posedge pclk);
        error_cnt++;
        report_and_stop();
    end

    // ========================================================
    // Main sequence
    initial begin
        presetn = 1'b0;
        req = '0;
        restart = 1'b1;
        nbits = NBITS_8;
        rd = $urandom(32'h240D);
        words = {9'($urandom), 9'($urandom),
                 9'($urandom) & 9'h0FF, 9'($urandom) | 9'h100};
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        restart <= 1'b0;
        // Reset values; ninth bit of an empty buffer is don't-care
        foreach (ridx[i]) begin
            apb(1'b0, ridx[i], 8'h00);
            chk(rd & 32'hFE, 32'(rrst[i] & 8'hFE));
        end
        apb(1'b0, 8'h01, 8'h00);
        chk({rd[30:0], err}, 32'h1);
        chk(32'({d_oe, d_out}), 32'h0);
        // Software setup with both enables clear
        apb(1'b1, IDX_BAUD, 8'h07);
        apb(1'b1, IDX_TRANSMIT_STATUS_CONTROL, 8'h90);
        apb(1'b1, IDX_RECEIVE_STATUS_CONTROL, 8'h80);
        apb(1'b0, IDX_BAUD, 8'h00);
        chk(rd, 32'h07);
        chk(32'(sck_oe), 32'h1);
        s = sck_cnt;
        repeat (40) @(posedge pclk);
        chk(32'(sck_cnt), 32'(s));
        // Single word, eight bits, interrupt blocked
        apb(1'b1, IDX_RECEIVE_STATUS_CONTROL, 8'hA0);
        wait_bit(IDX_FLAG, B_RECEIVE_DONE_FLAG);
        chk(rd, 32'h20);
        chk(32'(rx_irq), 32'h0);
        apb(1'b1, IDX_FLAG, 8'h00);
        apb(1'b0, IDX_FLAG, 8'h00);
        chk(rd, 32'h20);
        apb(1'b0, IDX_RECEIVE_STATUS_CONTROL, 8'h00);
        chk(rd, 32'h80);
        s = sck_cnt;
        repeat (60) @(posedge pclk);
        chk(32'(sck_cnt), 32'(s));
        apb(1'b1, IDX_PIE, 8'h20);
        @(negedge pclk);
        chk(32'(rx_irq), 32'h1);
        apb(1'b0, IDX_RCBUF, 8'h00);
        chk(rd, 32'(words[0][7:0]));
        apb(1'b0, IDX_FLAG, 8'h00);
        chk(rd, 32'h00);
        chk(32'(rx_irq), 32'h0);
        // Both enables, nine bits: run into overrun
        nbits <= NBITS_9;
        pulse_restart();
        apb(1'b1, IDX_RECEIVE_STATUS_CONTROL, 8'hF0);
        wait_bit(IDX_RECEIVE_STATUS_CONTROL, B_OVERRUN_ERROR_BIT);
        chk(rd, 32'hF2 | 32'(words[0][8]));
        chk(32'(rx_irq), 32'h1);
        apb(1'b0, IDX_RCBUF, 8'h00);
        chk(rd, 32'(words[0][7:0]));
        apb(1'b0, IDX_RECEIVE_STATUS_CONTROL, 8'h00);
        chk(rd, 32'hF2 | 32'(words[1][8]));
        apb(1'b0, IDX_RCBUF, 8'h00);
        chk(rd, 32'(words[1][7:0]));
        // More words finish while overrun stands; none may land
        s = rises;
        repeat (2000) if (rises < s + 20) @(posedge pclk);
        repeat (20) @(posedge pclk);
        apb(1'b0, IDX_FLAG, 8'h00);
        chk(rd, 32'h00);
        apb(1'b1, IDX_RECEIVE_STATUS_CONTROL, 8'h80);
        apb(1'b0, IDX_RECEIVE_STATUS_CONTROL, 8'h00);
        chk(rd & 32'hFE, 32'h80);
        report_and_stop();
    end
endmodule
